// File: adc_compare_result_config.sv
// register file, conversion sequencing, compare and clock divide of the converter
`timescale 1ns/100ps
`default_nettype none

module adc_compare_result_config
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // register port
    input  wire reg_req_t     reg_req,
    output var  logic [7:0]   reg_rdata,
    // pins from outside the clock domain
    input  wire logic         hardware_trigger_input,
    input  wire logic         alternate_clock_in,
    input  wire logic         internal_async_clock,
    // analog converter core
    output var  core_ctrl_t   core_ctrl,
    input  wire core_result_t core_result
);

    // helpers
    function automatic logic [9:0] round_raw(input logic [RAW_W-1:0] raw,
                                             input logic ten);
        logic [11:0] sum10;
        logic [9:0]  sum8;
        begin
            sum10 = {1'b0, raw} + 12'h001;
            sum8  = {1'b0, raw[8:0]} + 10'h001;
            if (ten) begin
                // half-step rounding can carry past full scale; clamp it
                round_raw = sum10[11] ? 10'h3ff : sum10[10:1];
            end else begin
                round_raw = sum8[9] ? 10'h0ff : {2'h0, sum8[8:1]};
            end
        end
    endfunction : round_raw

    function automatic logic compare_true(input logic [9:0] res,
                                          input logic [9:0] cv,
                                          input logic ten,
                                          input logic greater);
        logic [9:0] a;
        logic [9:0] b;
        begin
            a = ten ? res : {2'h0, res[7:0]};
            b = ten ? cv : {2'h0, cv[7:0]};
            compare_true = greater ? (a >= b) : (a < b);
        end
    endfunction : compare_true

    function automatic logic [2:0] divide_limit(input logic [1:0] sel);
        begin
            unique case (sel)
                2'h0: divide_limit = 3'h0;
                2'h1: divide_limit = 3'h1;
                2'h2: divide_limit = 3'h3;
                2'h3: divide_limit = 3'h7;
            endcase
        end
    endfunction : divide_limit

    // registers
    logic [7:0]  channel_start_reg;
    logic [7:0]  trigger_cmp_reg;
    logic [7:0]  cmp_upper_reg;
    logic [7:0]  cmp_lower_reg;
    logic [7:0]  config_reg;
    logic [9:0]  result_reg;
    logic        complete_reg;
    logic        interlock_reg;
    conv_state_t state_reg;
    logic [2:0]  sync1_reg;
    logic [2:0]  sync2_reg;
    logic [2:0]  sync3_reg;
    logic [2:0]  level_reg;
    logic        half_reg;
    logic [2:0]  div_cnt_reg;

    // field views
    logic [4:0] channel;
    logic       continuous;
    logic       trig_hw;
    logic       cmp_enable;
    logic       cmp_greater;
    logic [1:0] mode;
    logic       ten_bit;
    logic [1:0] clk_sel;
    logic [1:0] div_sel;

    assign channel     = channel_start_reg[CHANNEL_MSB:0];
    assign continuous  = channel_start_reg[CONTINUOUS_BIT];
    assign trig_hw     = trigger_cmp_reg[TRIGGER_BIT];
    assign cmp_enable  = trigger_cmp_reg[CMP_ENABLE_BIT];
    assign cmp_greater = trigger_cmp_reg[CMP_GREATER_BIT];
    assign mode        = config_reg[MODE_LSB+1:MODE_LSB];
    assign ten_bit     = (mode == MODE_10BIT);
    assign clk_sel     = config_reg[CLK_SEL_LSB+1:CLK_SEL_LSB];
    assign div_sel     = config_reg[DIVIDE_LSB+1:DIVIDE_LSB];

    // bus decode
    logic wr_start_ctl;
    logic wr_config;
    logic rd_upper;
    logic rd_lower;
    logic mode_change;

    assign wr_start_ctl = reg_req.wr && (reg_req.addr == OFS_CHANNEL_START);
    assign wr_config    = reg_req.wr && (reg_req.addr == OFS_CONFIG);
    assign rd_upper     = reg_req.rd && (reg_req.addr == OFS_RESULT_UPPER);
    assign rd_lower     = reg_req.rd && (reg_req.addr == OFS_RESULT_LOWER);
    assign mode_change  = wr_config &&
                          (reg_req.wdata[MODE_LSB+1:MODE_LSB] != mode);

    // pin synchronisers: trigger, alternate clock, async clock
    logic [2:0] pins;
    logic [2:0] rise;

    assign pins = {internal_async_clock, alternate_clock_in, hardware_trigger_input};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
            level_reg <= 3'h0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < 3; i++) begin
                // a change is believed only once two stages agree
                if (sync2_reg[i] == sync3_reg[i]) begin
                    level_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            rise[i] = (sync2_reg[i] == sync3_reg[i]) && sync3_reg[i] && !level_reg[i];
        end
    end

    // converter clock: source select then divide
    logic src_pulse;
    logic div_pulse;

    always_comb begin
        unique case (clk_sel)
            CLK_BUS:      src_pulse = 1'b1;
            CLK_BUS_HALF: src_pulse = half_reg;
            CLK_ALT:      src_pulse = rise[1];
            CLK_ASYNC:    src_pulse = rise[2];
        endcase
    end

    assign div_pulse = src_pulse && (div_cnt_reg == divide_limit(div_sel));

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            half_reg    <= 1'b0;
            div_cnt_reg <= 3'h0;
        end else begin
            half_reg <= !half_reg;
            // restart the divide on reconfiguration so no stale count stretches a period
            if (wr_config || div_pulse) begin
                div_cnt_reg <= 3'h0;
            end else if (src_pulse) begin
                div_cnt_reg <= div_cnt_reg + 3'h1;
            end
        end
    end

    // conversion sequencing
    logic sw_start;
    logic hw_start;
    logic cont_start;
    logic start_now;
    logic abort_now;
    logic done_ok;
    logic cond_ok;
    logic store_ok;
    logic [9:0] rounded;
    logic [9:0] cmp_value;

    assign sw_start   = wr_start_ctl && !trig_hw &&
                        (reg_req.wdata[CHANNEL_MSB:0] != CHANNEL_OFF);
    assign hw_start   = trig_hw && rise[0] && !wr_start_ctl &&
                        (state_reg == CONV_IDLE) && (channel != CHANNEL_OFF);
    // a result arriving in the cycle of an abort belongs to the aborted conversion
    assign done_ok    = core_result.done && (state_reg == CONV_BUSY) && !wr_start_ctl;
    assign cont_start = done_ok && continuous && (channel != CHANNEL_OFF);
    assign start_now  = sw_start || hw_start || cont_start;
    assign abort_now  = wr_start_ctl && (state_reg == CONV_BUSY);

    assign rounded   = round_raw(core_result.raw, ten_bit);
    assign cmp_value = {cmp_upper_reg[1:0], cmp_lower_reg};
    assign cond_ok   = !cmp_enable ||
                       compare_true(rounded, cmp_value, ten_bit, cmp_greater);
    assign store_ok  = done_ok && cond_ok && !interlock_reg && !mode_change;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= CONV_IDLE;
        end else if (start_now) begin
            state_reg <= CONV_BUSY;
        end else if (done_ok || abort_now) begin
            state_reg <= CONV_IDLE;
        end
    end

    // software registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            channel_start_reg <= CHANNEL_START_RESET;
        end else if (wr_start_ctl) begin
            channel_start_reg <= {1'b0, reg_req.wdata[6:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            trigger_cmp_reg <= TRIGGER_CMP_RESET;
        end else if (reg_req.wr && (reg_req.addr == OFS_TRIGGER_CMP)) begin
            // active flag is hardware owned; reserved bits are kept at zero
            trigger_cmp_reg <= {1'b0, reg_req.wdata[6:4], 4'h0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmp_upper_reg <= CMP_VALUE_RESET;
            cmp_lower_reg <= CMP_VALUE_RESET;
        end else if (reg_req.wr) begin
            if (reg_req.addr == OFS_CMP_UPPER) begin
                cmp_upper_reg <= {6'h00, reg_req.wdata[1:0]};
            end
            if (reg_req.addr == OFS_CMP_LOWER) begin
                cmp_lower_reg <= reg_req.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            config_reg <= CONFIG_RESET;
        end else if (wr_config) begin
            config_reg <= reg_req.wdata;
        end
    end

    // result, interlock and complete flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result_reg <= 10'h000;
        end else if (mode_change) begin
            result_reg <= 10'h000;
        end else if (store_ok) begin
            result_reg <= ten_bit ? rounded : {2'h0, rounded[7:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            interlock_reg <= 1'b0;
        end else if (mode_change || rd_lower) begin
            interlock_reg <= 1'b0;
        end else if (rd_upper && ten_bit) begin
            interlock_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            complete_reg <= 1'b0;
        end else if (done_ok && cond_ok) begin
            complete_reg <= 1'b1;
        end else if (wr_start_ctl || rd_lower) begin
            complete_reg <= 1'b0;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                OFS_CHANNEL_START: reg_rdata <= {complete_reg, channel_start_reg[6:0]};
                OFS_TRIGGER_CMP:   reg_rdata <= {state_reg == CONV_BUSY,
                                                 trigger_cmp_reg[6:0]};
                OFS_RESULT_UPPER:  reg_rdata <= {6'h00, result_reg[9:8]};
                OFS_RESULT_LOWER:  reg_rdata <= result_reg[7:0];
                OFS_CMP_UPPER:     reg_rdata <= cmp_upper_reg;
                OFS_CMP_LOWER:     reg_rdata <= cmp_lower_reg;
                OFS_CONFIG:        reg_rdata <= config_reg;
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // core command word
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            core_ctrl <= '0;
        end else begin
            core_ctrl.start       <= start_now;
            core_ctrl.abort       <= abort_now;
            core_ctrl.clk_en      <= div_pulse;
            core_ctrl.low_power   <= config_reg[LOW_POWER_BIT];
            core_ctrl.long_sample <= config_reg[LONG_SAMPLE_BIT];
            core_ctrl.ten_bit     <= ten_bit;
            core_ctrl.channel     <= wr_start_ctl ? reg_req.wdata[CHANNEL_MSB:0] : channel;
        end
    end

endmodule : adc_compare_result_config

`default_nettype wire

// File: adc_compare_result_config_chk.sv
// port assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none

module adc_compare_result_config_chk
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input wire logic         core_clk,
    input wire logic         rst_n,
    // register port
    input wire reg_req_t     reg_req,
    input wire logic [7:0]   reg_rdata,
    // pins
    input wire logic         hardware_trigger_input,
    input wire logic         alternate_clock_in,
    input wire logic         internal_async_clock,
    // core link
    input wire core_ctrl_t   core_ctrl,
    input wire core_result_t core_result
);
    logic [7:0] cfg_reg;
    logic       trig_reg;
    logic       cont_reg;
    logic [4:0] since_reg;
    logic [3:0] gap_reg;
    wire        wr_sc1 = reg_req.wr && reg_req.addr == OFS_CHANNEL_START;
    wire        wr_cfg = reg_req.wr && reg_req.addr == OFS_CONFIG;
    wire        rd_sc2 = reg_req.rd && reg_req.addr == OFS_TRIGGER_CMP;
    // divider checks wait until a restart after a config write has settled
    wire        settled = cfg_reg[1:0] == CLK_BUS && since_reg > 5'h14;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_reg <= CONFIG_RESET;
            trig_reg <= 1'b0;
            cont_reg <= 1'b0;
        end else begin
            if (wr_cfg)
                cfg_reg <= reg_req.wdata;
            if (reg_req.wr && reg_req.addr == OFS_TRIGGER_CMP)
                trig_reg <= reg_req.wdata[TRIGGER_BIT];
            if (wr_sc1)
                cont_reg <= reg_req.wdata[CONTINUOUS_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || wr_cfg)
            since_reg <= 5'h00;
        else if (since_reg != 5'h1f)
            since_reg <= since_reg + 5'h01;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || core_ctrl.clk_en)
            gap_reg <= 4'h0;
        else if (gap_reg != 4'hf)
            gap_reg <= gap_reg + 4'h1;
    end

    property p_sw_start;
        wr_sc1 && reg_req.wdata[4:0] != CHANNEL_OFF && !trig_reg |=> core_ctrl.start;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start missing");
    property p_off_no_start;
        wr_sc1 && reg_req.wdata[4:0] == CHANNEL_OFF |=> !core_ctrl.start;
    endproperty
    a_off_no_start: assert property (p_off_no_start)
        else $error("start with channel off");
    property p_start_cause;
        core_ctrl.start && !trig_reg && !cont_reg |-> $past(wr_sc1);
    endproperty
    a_start_cause: assert property (p_start_cause)
        else $error("start without control write");
    property p_abort;
        $past(core_ctrl.start) && wr_sc1 && reg_req.wdata[4:0] != CHANNEL_OFF && !trig_reg
            |=> core_ctrl.abort && core_ctrl.start;
    endproperty
    a_abort: assert property (p_abort)
        else $error("restart did not abort");
    property p_active;
        $past(core_ctrl.start) && rd_sc2 |=> reg_rdata[ACTIVE_BIT];
    endproperty
    a_active: assert property (p_active)
        else $error("active flag low in conversion");
    property p_reserved;
        rd_sc2 |=> reg_rdata[3:0] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits not zero");
    property p_upper;
        reg_req.rd && reg_req.addr == OFS_RESULT_UPPER |=> reg_rdata[7:2] == 6'h00
            && ($past(cfg_reg[3:2]) == MODE_10BIT || reg_rdata[1:0] == 2'h0);
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper result bits wrong");
    property p_cfg_copy;
        wr_cfg |-> ##2 core_ctrl.low_power == $past(reg_req.wdata[LOW_POWER_BIT], 2)
            && core_ctrl.long_sample == $past(reg_req.wdata[LONG_SAMPLE_BIT], 2)
            && core_ctrl.ten_bit == ($past(reg_req.wdata[3:2], 2) == MODE_10BIT);
    endproperty
    a_cfg_copy: assert property (p_cfg_copy)
        else $error("core settings differ from config");
    property p_div1;
        settled && cfg_reg[6:5] == 2'h0 |-> core_ctrl.clk_en;
    endproperty
    a_div1: assert property (p_div1)
        else $error("undivided tick missing");
    property p_div8;
        core_ctrl.clk_en && settled && cfg_reg[6:5] == 2'h3 |-> gap_reg == 4'h7;
    endproperty
    a_div8: assert property (p_div8)
        else $error("divide by eight spacing wrong");
endmodule : adc_compare_result_config_chk

`default_nettype wire

// File: adc_core_model.sv
// behavioural converter core: start pulse, tick count, completion strobe
`timescale 1ns/100ps
`default_nettype none

module adc_core_model
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input wire logic             core_clk,
    input wire logic             rst_n,
    // control and result
    input wire core_ctrl_t       core_ctrl,
    input wire logic [RAW_W-1:0] raw_in,
    output var core_result_t     core_result
);
    logic             busy_reg;
    logic [3:0]       tick_reg;
    // long sample stretches the conversion by two ticks
    wire  [3:0]       ticks = core_ctrl.long_sample ? 4'h8 : 4'h6;
    wire              fin = rst_n && busy_reg && core_ctrl.clk_en && tick_reg == ticks - 4'h1
                            && !core_ctrl.abort && !core_ctrl.start;
    // an 8-bit conversion yields only nine raw bits
    wire  [RAW_W-1:0] data = core_ctrl.ten_bit ? raw_in : {2'h0, raw_in[8:0]};

    always_ff @(posedge core_clk) begin
        if (!rst_n || core_ctrl.abort || fin)
            busy_reg <= 1'b0;
        if (core_ctrl.start)
            busy_reg <= 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || core_ctrl.start)
            tick_reg <= 4'h0;
        else if (busy_reg && core_ctrl.clk_en)
            tick_reg <= tick_reg + 4'h1;
    end

    // raw is only meaningful with done; otherwise it shows the inverse
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            core_result <= '0;
        end else begin
            core_result.done <= fin;
            core_result.raw <= fin ? data : ~core_result.raw;
        end
    end
endmodule : adc_core_model

`default_nettype wire

// File: adc_ctrl_pkg.sv
// constants, types and field layout of the converter control block
// How it works
// - active flag: set at start, cleared done/abort
// - trigger select: software write or hardware trigger
// - bit 5 enables automatic compare, all modes
// - bit 4: less-than or greater-or-equal compare
// - upper result bits; zero in 8-bit mode
// - load results unless compare enabled and false
// - 10-bit: upper read blocks transfers until lower read
// - results completing under interlock are discarded
// - 8-bit mode has no read interlock
// - mode change invalidates both result registers
// - lower register holds low eight result bits
// - upper compare bits used only in 10-bit
// - lower compare bits used in both modes
// - config bit 7 selects low-power operating point
// - config bits 6:5 divide clock 1/2/4/8
// - config bit 4 selects long sample period
// - config bits 3:2 select 8 or 10 bit
// - config bits 1:0 select input clock source
// - complete flag set when compare disabled or true
// - complete flag cleared by control write, lower read
// - control write aborts; restarts unless channel off or hardware trigger selected
// - raw result rounded to 10 or 8 bits
package adc_ctrl_pkg;

    // register offsets
    localparam logic [2:0] OFS_CHANNEL_START = 3'h0;
    localparam logic [2:0] OFS_TRIGGER_CMP   = 3'h1;
    localparam logic [2:0] OFS_RESULT_UPPER  = 3'h2;
    localparam logic [2:0] OFS_RESULT_LOWER  = 3'h3;
    localparam logic [2:0] OFS_CMP_UPPER     = 3'h4;
    localparam logic [2:0] OFS_CMP_LOWER     = 3'h5;
    localparam logic [2:0] OFS_CONFIG        = 3'h6;

    // channel_start_control fields
    localparam int COMPLETE_BIT   = 7;
    localparam int INT_ENABLE_BIT = 6;
    localparam int CONTINUOUS_BIT = 5;
    localparam int CHANNEL_MSB    = 4;

    // trigger_compare_control fields
    localparam int ACTIVE_BIT     = 7;
    localparam int TRIGGER_BIT    = 6;
    localparam int CMP_ENABLE_BIT = 5;
    localparam int CMP_GREATER_BIT = 4;

    // converter_configuration fields
    localparam int LOW_POWER_BIT  = 7;
    localparam int DIVIDE_LSB     = 5;
    localparam int LONG_SAMPLE_BIT = 4;
    localparam int MODE_LSB       = 2;
    localparam int CLK_SEL_LSB    = 0;

    localparam logic [1:0] MODE_8BIT  = 2'h0;
    localparam logic [1:0] MODE_10BIT = 2'h2;
    localparam logic [1:0] CLK_BUS      = 2'h0;
    localparam logic [1:0] CLK_BUS_HALF = 2'h1;
    localparam logic [1:0] CLK_ALT      = 2'h2;
    localparam logic [1:0] CLK_ASYNC    = 2'h3;

    localparam logic [4:0] CHANNEL_OFF = 5'h1f;

    // reset values
    localparam logic [7:0] CHANNEL_START_RESET = 8'h1f;
    localparam logic [7:0] TRIGGER_CMP_RESET   = 8'h00;
    localparam logic [7:0] CMP_VALUE_RESET     = 8'h00;
    localparam logic [7:0] CONFIG_RESET        = 8'h00;

    localparam int RAW_W = 11;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic       start;
        logic       abort;
        logic       clk_en;
        logic       low_power;
        logic       long_sample;
        logic       ten_bit;
        logic [4:0] channel;
    } core_ctrl_t;

    typedef struct packed {
        logic             done;
        logic [RAW_W-1:0] raw;
    } core_result_t;

    typedef enum logic {CONV_IDLE, CONV_BUSY} conv_state_t;

endpackage : adc_ctrl_pkg

// File: tb_adc_compare_result_config.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none

module tb_adc_compare_result_config
    import adc_ctrl_pkg::*;
;
    logic             core_clk = 1'b0;
    logic             rst_n = 1'b0;
    reg_req_t         reg_req = '0;
    logic [7:0]       reg_rdata;
    logic             hw_trig = 1'b0;
    logic [2:0]       slow_reg = 3'h0;
    core_ctrl_t       core_ctrl;
    core_result_t     core_result;
    logic [RAW_W-1:0] raw_in = '0;
    logic [7:0]       exp_q[$];
    logic             rd_seen = 1'b0;
    logic [15:0]      seed = 16'h000f;
    logic [9:0]       held;
    logic [9:0]       r;
    logic [9:0]       cv;
    logic             hit;
    int               miscompares = 0;
    int               samples_checked = 0;
    int               k;
    int               j;

    always #20 core_clk = ~core_clk;
    always @(posedge core_clk)
        slow_reg <= slow_reg + 3'h1;

    adc_compare_result_config dut (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .hardware_trigger_input(hw_trig),
        .alternate_clock_in(slow_reg[1]), .internal_async_clock(slow_reg[2]),
        .core_ctrl(core_ctrl), .core_result(core_result));
    adc_core_model core (.core_clk(core_clk), .rst_n(rst_n), .core_ctrl(core_ctrl),
        .raw_in(raw_in), .core_result(core_result));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [9:0] rnd(input logic [RAW_W-1:0] v, input logic ten);
        logic [RAW_W:0] s;
        s = ({1'b0, ten ? v : {2'h0, v[8:0]}} + 12'h001) >> 1;
        if (ten)
            return (s > 12'h3ff) ? 10'h3ff : s[9:0];
        return (s > 12'h0ff) ? 10'h0ff : s[9:0];
    endfunction : rnd

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check8

    // read data stands only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (rd_seen === 1'b1)
            check8(reg_rdata, exp_q.pop_front());
        rd_seen <= reg_req.rd;
    end

    task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
        reg_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge core_clk);
        reg_req <= '0;
        @(posedge core_clk);
    endtask : bus

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(a, d, 1'b1);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(a, 8'h00, 1'b0);
    endtask : rd

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (core_result.done !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            miscompares++;
            print_verdict();
        end
    endtask : wait_done

    task automatic conv(input logic [RAW_W-1:0] v);
        raw_in <= v;
        wr(OFS_CHANNEL_START, 8'h03);
        wait_done();
    endtask : conv

    initial begin
        #2000000;
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(OFS_CHANNEL_START, CHANNEL_START_RESET);
        for (k = 1; k < 8; k++)
            rd(k[2:0], 8'h00);
        wr(OFS_CHANNEL_START, 8'h1f);
        $display("reset test done");
        wr(OFS_CONFIG, 8'h08);
        seed = lfsr(seed);
        raw_in <= seed[RAW_W-1:0];
        wr(OFS_CHANNEL_START, 8'h03);
        wr(OFS_CHANNEL_START, 8'h03);
        rd(OFS_TRIGGER_CMP, 8'h80);
        wait_done();
        r = rnd(seed[RAW_W-1:0], 1'b1);
        rd(OFS_TRIGGER_CMP, 8'h00);
        rd(OFS_CHANNEL_START, 8'h83);
        rd(OFS_RESULT_UPPER, {6'h00, r[9:8]});
        rd(OFS_RESULT_LOWER, r[7:0]);
        rd(OFS_CHANNEL_START, 8'h03);
        $display("ten bit test done");
        seed = lfsr(seed);
        conv(seed[RAW_W-1:0]);
        held = rnd(seed[RAW_W-1:0], 1'b1);
        rd(OFS_RESULT_UPPER, {6'h00, held[9:8]});
        seed = lfsr(seed);
        conv(seed[RAW_W-1:0]);
        rd(OFS_RESULT_LOWER, held[7:0]);
        $display("interlock test done");
        wr(OFS_CONFIG, 8'h00);
        rd(OFS_RESULT_LOWER, 8'h00);
        seed = lfsr(seed);
        conv(seed[RAW_W-1:0]);
        rd(OFS_RESULT_UPPER, 8'h00);
        seed = lfsr(seed);
        conv(seed[RAW_W-1:0]);
        held = rnd(seed[RAW_W-1:0], 1'b0);
        rd(OFS_RESULT_LOWER, held[7:0]);
        $display("eight bit test done");
        for (k = 0; k < 4; k++) begin
            wr(OFS_CONFIG, k[1] ? 8'h08 : 8'h00);
            if (k == 2)
                held = 10'h000;
            wr(OFS_TRIGGER_CMP, {3'h1, k[0], 4'h0});
            for (j = 0; j < 3; j++) begin
                seed = lfsr(seed);
                wr(OFS_CMP_UPPER, {6'h00, seed[1:0]});
                wr(OFS_CMP_LOWER, seed[9:2]);
                cv = k[1] ? {seed[1:0], seed[9:2]} : {2'h0, seed[9:2]};
                seed = lfsr(seed);
                conv(seed[RAW_W-1:0]);
                r = rnd(seed[RAW_W-1:0], k[1]);
                hit = k[0] ? (r >= cv) : (r < cv);
                if (hit)
                    held = r;
                rd(OFS_CHANNEL_START, {hit, 7'h03});
                rd(OFS_RESULT_LOWER, held[7:0]);
            end
        end
        $display("compare test done");
        wr(OFS_TRIGGER_CMP, 8'h40);
        rd(OFS_TRIGGER_CMP, 8'h40);
        seed = lfsr(seed);
        raw_in <= seed[RAW_W-1:0];
        wr(OFS_CHANNEL_START, 8'h03);
        hw_trig <= 1'b1;
        repeat (4) @(posedge core_clk);
        hw_trig <= 1'b0;
        wait_done();
        r = rnd(seed[RAW_W-1:0], 1'b1);
        rd(OFS_RESULT_LOWER, r[7:0]);
        wr(OFS_TRIGGER_CMP, 8'h00);
        wr(OFS_CHANNEL_START, 8'h23);
        wait_done();
        wait_done();
        wr(OFS_CHANNEL_START, 8'h1f);
        rd(OFS_TRIGGER_CMP, 8'h00);
        rd(OFS_RESULT_LOWER, r[7:0]);
        $display("hardware trigger test done");
        for (k = 0; k < 16; k++) begin
            wr(OFS_CONFIG, {k[0], k[3:2], k[1], 2'h2, k[1:0]});
            seed = lfsr(seed);
            conv(seed[RAW_W-1:0]);
            r = rnd(seed[RAW_W-1:0], 1'b1);
            rd(OFS_RESULT_LOWER, r[7:0]);
        end
        $display("clock test done");
        repeat (4) @(posedge core_clk);
        print_verdict();
    end
endmodule : tb_adc_compare_result_config

bind adc_compare_result_config adc_compare_result_config_chk chk (
    .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .hardware_trigger_input(hardware_trigger_input), .alternate_clock_in(alternate_clock_in),
    .internal_async_clock(internal_async_clock), .core_ctrl(core_ctrl),
    .core_result(core_result));

`default_nettype wire
